// file: common/ftbsp_pkg.sv
// constants and types shared by the flow-through burst sram port
package ftbsp_pkg;
    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W  = 18;
    localparam int DEPTH   = 262144;
    localparam int LANES   = 4;
    localparam int LANE_W  = 8;
    localparam int SLICE_W = 9;
    localparam int DATA_W  = 32;
    localparam int WORD_W  = 36;
    localparam int BCNT_W  = 2;
    localparam int HI_W    = 16;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [BCNT_W-1:0] BCNT_RST  = 2'h0;
    localparam logic [HI_W-1:0]   HI_RST    = 16'h0000;
    localparam logic [WORD_W-1:0] DATA_RST  = 36'h000000000;
    localparam logic              MODE_RST  = 1'h1;
    localparam logic              RD_RST    = 1'h0;
    localparam logic [LANES-1:0]  ALL_LANES = 4'hF;
    localparam logic [LANES-1:0]  NO_LANES  = 4'h0;
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SEL_DESEL  = 2'h0,
        SEL_FIRST  = 2'h1,
        SEL_ACTIVE = 2'h3
    } ftbsp_sel_t;

    typedef struct packed {
        logic [BCNT_W-1:0] start;
        logic [BCNT_W-1:0] offset;
    } ftbsp_bcnt_state_t;

    typedef struct packed {
        ftbsp_sel_t        sel;
        logic              rd;
        logic [HI_W-1:0]   addr_hi;
        logic [WORD_W-1:0] rd_data;
        logic              mode_meta;
        logic              mode;
    } ftbsp_port_state_t;
endpackage : ftbsp_pkg

// file: common/ftbsp_burst_if.sv
// carrier between the port control and its burst counter
`timescale 1ns/10ps
`default_nettype none
interface ftbsp_burst_if;
    import ftbsp_pkg::*;
    logic              load;
    logic              advance;
    logic              linear;
    logic [BCNT_W-1:0] load_value;
    logic [BCNT_W-1:0] next_low;

    modport ctrl    (output load, output advance, output linear, output load_value,
                     input next_low);
    modport counter (input load, input advance, input linear, input load_value,
                     output next_low);
endinterface : ftbsp_burst_if
`default_nettype wire

// file: verilog/ftbsp_burst_counter.sv
// two-bit burst counter with linear and interleaved order
`timescale 1ns/10ps
`default_nettype none
module ftbsp_burst_counter (
    input  wire logic      i_clk,
    input  wire logic      i_nrst,
    ftbsp_burst_if.counter bus
);
    import ftbsp_pkg::*;

    ftbsp_bcnt_state_t state_reg;
    ftbsp_bcnt_state_t state_next;
    logic [BCNT_W-1:0] off_step;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        off_step   = state_reg.offset + {1'h0, bus.advance};
        if (bus.load)
        begin
            state_next.start  = bus.load_value;
            state_next.offset = BCNT_RST;
        end
        else
        begin
            state_next.offset = off_step;
        end
        // two-bit sums wrap inside the aligned group of four
        if (bus.load)
            bus.next_low = bus.load_value;
        else if (bus.linear)
            bus.next_low = state_reg.start + off_step;
        else
            bus.next_low = state_reg.start ^ off_step;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            state_reg <= '{start: BCNT_RST, offset: BCNT_RST};
        else
            state_reg <= state_next;
    end
endmodule : ftbsp_burst_counter
`default_nettype wire

// file: verilog/ftbsp_sram_port.sv
// flow-through burst sram port: address capture, selection, writes, output drive
`timescale 1ns/10ps
`default_nettype none
// Operation
// - address taken when a strobe is low and all chip selects are active.
// - low two address bits load the burst counter.
// - processor strobe captures address; it wins when both strobes are low.
// - processor strobe ignored while first chip select is high.
// - selected only with first low, second high, third low.
// - four lane selects write their lane only when the qualifier is low.
// - all-lanes write low writes every lane, ignoring selects and qualifier.
// - burst counter advances on each edge with burst advance low, no address strobe taken and the port still selected.
// - output enable low drives data pins, high three-states them.
// - outputs stay off during first read clock after deselected state.
// - burst order pin low linear, high or open interleaved, static.
// - data pins show the word addressed at the previous rising edge.
module ftbsp_sram_port (
    input  wire logic                       i_clk,
    input  wire logic                       i_nrst,
    input  wire logic [ftbsp_pkg::ADDR_W-1:0] i_addr,
    input  wire logic                       i_processor_addr_strobe_n,
    input  wire logic                       i_controller_addr_strobe_n,
    input  wire logic                       i_burst_advance_n,
    input  wire logic                       i_all_lanes_write_n,
    input  wire logic                       i_lane_write_qualifier_n,
    input  wire logic [ftbsp_pkg::LANES-1:0]  i_lane_write_select_n,
    input  wire logic                       i_chip_select_first_n,
    input  wire logic                       i_chip_select_second,
    input  wire logic                       i_chip_select_third_n,
    input  wire logic                       i_output_enable_n,
    input  wire logic                       i_burst_order,
    input  wire logic [ftbsp_pkg::DATA_W-1:0] i_dq,
    output var  logic [ftbsp_pkg::DATA_W-1:0] o_dq,
    output var  logic                       o_dq_oe,
    input  wire logic [ftbsp_pkg::LANES-1:0]  i_lane_parity_io,
    output var  logic [ftbsp_pkg::LANES-1:0]  o_lane_parity_io,
    output var  logic                       o_lane_parity_io_oe
);
    import ftbsp_pkg::*;

    // ------------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] mem [DEPTH];

    ftbsp_port_state_t state_reg;
    ftbsp_port_state_t state_next;

    ftbsp_burst_if burst ();

    logic              selected;
    logic              proc_start;
    logic              ctl_start;
    logic              start;
    logic              access;
    logic [ADDR_W-1:0] eff_addr;
    logic [LANES-1:0]  lane_we;
    logic              is_write;
    logic [WORD_W-1:0] wr_word;

    // ------------------------------------------------------------------
    // decode of the sampled control inputs
    // ------------------------------------------------------------------
    always_comb
    begin
        selected   = !i_chip_select_first_n && i_chip_select_second
                     && !i_chip_select_third_n;
        proc_start = !i_processor_addr_strobe_n && !i_chip_select_first_n;
        // processor start takes precedence, so the controller strobe only matters when no processor start is taken
        ctl_start  = !proc_start && !i_controller_addr_strobe_n;
        start      = proc_start || ctl_start;
        // a start edge re-decides selection; continuation edges keep the last one
        access     = start ? selected : (state_reg.sel != SEL_DESEL);
        if (!i_all_lanes_write_n)
            lane_we = ALL_LANES;
        else if (!i_lane_write_qualifier_n)
            lane_we = ~i_lane_write_select_n;
        else
            lane_we = NO_LANES;
        is_write   = access && (lane_we != NO_LANES);
    end

    // ------------------------------------------------------------------
    // burst counter control
    // ------------------------------------------------------------------
    assign burst.load       = start && selected;
    assign burst.load_value = i_addr[BCNT_W-1:0];
    assign burst.advance    = !start && access && !i_burst_advance_n;
    assign burst.linear     = !state_reg.mode;

    ftbsp_burst_counter u_counter (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .bus    (burst.counter)
    );

    always_comb
    begin
        if (burst.load)
            eff_addr = i_addr;
        else
            eff_addr = {state_reg.addr_hi, burst.next_low};
    end

    // ------------------------------------------------------------------
    // lane packing of write data and unpacking of read data
    // ------------------------------------------------------------------
    for (genvar l = 0; l < LANES; l++)
    begin : g_lane
        assign wr_word[l*SLICE_W +: SLICE_W] = {i_lane_parity_io[l], i_dq[l*LANE_W +: LANE_W]};
        assign o_dq[l*LANE_W +: LANE_W]      = state_reg.rd_data[l*SLICE_W +: LANE_W];
        assign o_lane_parity_io[l]           = state_reg.rd_data[l*SLICE_W + LANE_W];
    end

    // ------------------------------------------------------------------
    // array write: lanes not enabled keep their old contents
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        for (int l = 0; l < LANES; l++)
        begin
            if (access && lane_we[l])
                mem[eff_addr][l*SLICE_W +: SLICE_W] <= wr_word[l*SLICE_W +: SLICE_W];
        end
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_next           = state_reg;
        // strap pin is async to us, so it goes through two flops first
        state_next.mode_meta = i_burst_order;
        state_next.mode      = state_reg.mode_meta;
        if (burst.load)
            state_next.addr_hi = i_addr[ADDR_W-1:BCNT_W];
        if (!access)
        begin
            state_next.sel = SEL_DESEL;
            state_next.rd  = 1'h0;
        end
        else if (is_write)
        begin
            state_next.sel = SEL_ACTIVE;
            state_next.rd  = 1'h0;
        end
        else
        begin
            // flow-through: the word appears right after the addressing edge
            state_next.rd_data = mem[eff_addr];
            state_next.rd      = 1'h1;
            case (state_reg.sel)
                SEL_DESEL: state_next.sel = SEL_FIRST;
                SEL_FIRST: state_next.sel = SEL_ACTIVE;
                SEL_ACTIVE: state_next.sel = SEL_ACTIVE;
                default:   state_next.sel = SEL_DESEL;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            state_reg <= '{sel:       SEL_DESEL,
                           rd:        RD_RST,
                           addr_hi:   HI_RST,
                           rd_data:   DATA_RST,
                           mode_meta: MODE_RST,
                           mode:      MODE_RST};
        else
            state_reg <= state_next;
    end

    // ------------------------------------------------------------------
    // output drive
    // ------------------------------------------------------------------
    // the enable pin is deliberately not synchronised: it gates the drivers
    // directly so turn-on and turn-off follow the pin without clock latency
    always_comb
    begin
        o_dq_oe = (state_reg.sel == SEL_ACTIVE) && state_reg.rd
                  && !i_output_enable_n;
        o_lane_parity_io_oe = o_dq_oe;
    end
endmodule : ftbsp_sram_port
`default_nettype wire

// file: verification/ftbsp_monitor.sv
// concurrent checks on the sram port pins
`timescale 1ns/10ps
`default_nettype none
module ftbsp_monitor (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_processor_addr_strobe_n,
    input wire logic i_controller_addr_strobe_n,
    input wire logic i_burst_advance_n,
    input wire logic i_all_lanes_write_n,
    input wire logic i_lane_write_qualifier_n,
    input wire logic [ftbsp_pkg::LANES-1:0] i_lane_write_select_n,
    input wire logic i_chip_select_first_n,
    input wire logic i_chip_select_second,
    input wire logic i_chip_select_third_n,
    input wire logic i_output_enable_n,
    input wire logic [ftbsp_pkg::DATA_W-1:0] o_dq,
    input wire logic o_dq_oe,
    input wire logic o_lane_parity_io_oe
);
    // ------------
    // decode
    // ------------
    wire st = !i_controller_addr_strobe_n
        | (!i_processor_addr_strobe_n & !i_chip_select_first_n);
    wire sl = !i_chip_select_first_n & i_chip_select_second & !i_chip_select_third_n;
    wire rd = i_all_lanes_write_n & (i_lane_write_qualifier_n | &i_lane_write_select_n);
    wire cn = i_processor_addr_strobe_n & i_controller_addr_strobe_n;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_desel; st && !sl; endsequence
    sequence s_rdst; st && sl && rd; endsequence
    sequence s_step; cn && rd && !i_burst_advance_n && !i_output_enable_n; endsequence
    property p_desel; s_desel |=> !o_dq_oe; endproperty
    property p_first; s_desel ##1 s_rdst |=> !o_dq_oe; endproperty
    property p_second; s_desel ##1 s_rdst ##1 s_step |=> o_dq_oe || i_output_enable_n;
    endproperty
    property p_oe_off; i_output_enable_n |-> !o_dq_oe; endproperty
    property p_pair; o_dq_oe == o_lane_parity_io_oe; endproperty
    // processor strobe with first select high continues the burst, never deselects
    property p_ign; o_dq_oe && rd && i_chip_select_first_n && !i_processor_addr_strobe_n
        && i_controller_addr_strobe_n |=> o_dq_oe || i_output_enable_n; endproperty
    property p_wr; st && sl && !i_all_lanes_write_n |=> !o_dq_oe; endproperty
    // re-read without advance must not disturb the pins
    property p_hold; o_dq_oe && cn && rd && i_burst_advance_n |=> $stable(o_dq);
    endproperty
    a_desel: assert property (p_desel) else $error("drive after deselect");
    a_first: assert property (p_first) else $error("first read driven");
    a_second: assert property (p_second) else $error("second read idle");
    a_oe_off: assert property (p_oe_off) else $error("drive with oe high");
    a_pair: assert property (p_pair) else $error("parity oe differs");
    a_ign: assert property (p_ign) else $error("strobe not ignored");
    a_wr: assert property (p_wr) else $error("drive after write");
    a_hold: assert property (p_hold) else $error("data moved on hold");
endmodule : ftbsp_monitor
bind ftbsp_sram_port ftbsp_monitor mon_u (.i_clk, .i_nrst, .i_processor_addr_strobe_n,
    .i_controller_addr_strobe_n, .i_burst_advance_n, .i_all_lanes_write_n,
    .i_lane_write_qualifier_n, .i_lane_write_select_n, .i_chip_select_first_n,
    .i_chip_select_second, .i_chip_select_third_n, .i_output_enable_n, .o_dq,
    .o_dq_oe, .o_lane_parity_io_oe);
`default_nettype wire

// file: verification/ftbsp_ctrl_model.sv
// controller model driving the sram port pins
`timescale 1ns/10ps
`default_nettype none
module ftbsp_ctrl_model (
    input  wire logic        i_clk,
    input  wire logic [35:0] i_rd_word,
    input  wire logic        i_rd_oe,
    output var  logic [30:0] o_ctl,
    output var  logic [35:0] o_bus
);
    import ftbsp_pkg::*;
    logic [35:0] wd = 36'h000000000;
    logic        drv = 1'b0;
    initial o_ctl = {13'h1FF4, 18'h00000};
    // released bus shows the inverse so a stale word never reads as good
    always_comb o_bus = i_rd_oe ? i_rd_word : (drv ? wd : ~wd);
    // qualifier and lane selects change together in one control word
    task cyc(input logic [12:0] c, input logic [17:0] a, input logic [35:0] d,
        input logic w);
        @(negedge i_clk);
        o_ctl = {c, a};
        wd = d;
        drv = w;
        @(posedge i_clk);
        #1;
    endtask : cyc
endmodule : ftbsp_ctrl_model
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for the sram port
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
    import ftbsp_pkg::*;
    localparam logic [12:0] IDL = 13'h1FF4, K_PSTB = 13'h1000, K_CSTB = 13'h0800,
        K_STEP = 13'h0400, K_ALLW = 13'h0200, K_QUAL = 13'h0100, K_LANE0 = 13'h0010,
        K_DSEL1 = 13'h0008, K_DSEL2 = 13'h0004, K_OFF = 13'h0001;
    logic            i_clk = 1'b0;
    logic            i_nrst = 1'b0;
    wire logic [30:0] ctl;
    wire logic [35:0] bus;
    wire logic [DATA_W-1:0] o_dq;
    wire logic [LANES-1:0] o_par;
    wire logic       o_oe, o_par_oe;
    logic [35:0]     exp_w [4];
    logic            burst_order = 1'b0;
    int              errors = 0, n_checks = 0;
    // ------------
    // block and controller
    // ------------
    ftbsp_sram_port dut_u (.i_clk, .i_nrst, .i_addr(ctl[17:0]),
        .i_processor_addr_strobe_n(ctl[30]), .i_controller_addr_strobe_n(ctl[29]),
        .i_burst_advance_n(ctl[28]), .i_all_lanes_write_n(ctl[27]),
        .i_lane_write_qualifier_n(ctl[26]), .i_lane_write_select_n(ctl[25:22]),
        .i_chip_select_first_n(ctl[21]), .i_chip_select_second(ctl[20]),
        .i_chip_select_third_n(ctl[19]), .i_output_enable_n(ctl[18]),
        .i_burst_order(burst_order), .i_dq(bus[31:0]), .o_dq, .o_dq_oe(o_oe),
        .i_lane_parity_io(bus[35:32]), .o_lane_parity_io(o_par),
        .o_lane_parity_io_oe(o_par_oe));
    ftbsp_ctrl_model ctl_u (.i_clk, .i_rd_word({o_par, o_dq}), .i_rd_oe(o_oe),
        .o_ctl(ctl), .o_bus(bus));
    always #20 i_clk = ~i_clk;
    task automatic rd_chk(input logic oe, input int i);
        `CHK("oe", oe, o_oe);
        `CHK("word", exp_w[i], {o_par, o_dq});
    endtask : rd_chk
    task automatic t_burst_write;
        for (int k = 0; k < 4; k++)
        begin
            exp_w[(k + 1) % 4] = {4'(k + 5), 32'h1234_5600 + 32'(k * 273)};
            ctl_u.cyc(k == 0 ? IDL ^ K_CSTB ^ K_ALLW : IDL ^ K_STEP ^ K_ALLW, 18'h00011,
                exp_w[(k + 1) % 4], 1'b1);
            `CHK("oe", 1'b0, o_oe);
        end
    endtask : t_burst_write
    task automatic t_lane_write;
        ctl_u.cyc(IDL ^ K_CSTB ^ K_QUAL ^ K_LANE0, 18'h00010, 36'hF_FFFF_FFFF, 1'b1);
        exp_w[0][7:0] = 8'hFF;
        exp_w[0][32] = 1'b1;
        ctl_u.cyc(IDL ^ K_CSTB ^ K_LANE0, 18'h00012, 36'h0, 1'b0);
        rd_chk(1'b1, 2);
    endtask : t_lane_write
    task automatic t_read_burst;
        ctl_u.cyc(IDL ^ K_CSTB ^ K_DSEL2, 18'h00000, 36'h0, 1'b0);
        `CHK("oe", 1'b0, o_oe);
        ctl_u.cyc(IDL ^ K_PSTB, 18'h00011, 36'h0, 1'b0);
        rd_chk(1'b0, 1);
        for (int k = 1; k < 5; k++)
        begin
            ctl_u.cyc(IDL ^ K_STEP, 18'h00000, 36'h0, 1'b0);
            rd_chk(1'b1, (k + 1) % 4);
        end
        ctl_u.cyc(IDL, 18'h00000, 36'h0, 1'b0);
        rd_chk(1'b1, 1);
        ctl_u.cyc(IDL ^ K_OFF, 18'h00000, 36'h0, 1'b0);
        rd_chk(1'b0, 1);
    endtask : t_read_burst
    // with first select high a processor strobe must not break a running burst
    task automatic t_strobe_ignored;
        ctl_u.cyc(IDL ^ K_CSTB, 18'h00012, 36'h0, 1'b0);
        rd_chk(1'b1, 2);
        ctl_u.cyc(IDL ^ K_PSTB ^ K_DSEL1, 18'h00013, 36'h0, 1'b0);
        rd_chk(1'b1, 2);
        ctl_u.cyc(IDL ^ K_CSTB ^ K_DSEL1, 18'h00000, 36'h0, 1'b0);
        `CHK("oe", 1'b0, o_oe);
    endtask : t_strobe_ignored
    task automatic t_interleave;
        @(negedge i_clk);
        burst_order = 1'b1;
        // strap passes two flops before the counter sees it
        repeat (2) ctl_u.cyc(IDL, 18'h00000, 36'h0, 1'b0);
        ctl_u.cyc(IDL ^ K_CSTB, 18'h00011, 36'h0, 1'b0);
        rd_chk(1'b0, 1);
        for (int k = 1; k < 4; k++)
        begin
            ctl_u.cyc(IDL ^ K_STEP, 18'h00000, 36'h0, 1'b0);
            rd_chk(1'b1, 1 ^ k);
        end
    endtask : t_interleave
    task automatic t_reset;
        ctl_u.cyc(IDL, 18'h00000, 36'h0, 1'b0);
        rd_chk(1'b1, 2);
        @(negedge i_clk);
        i_nrst = 1'b0;
        #1;
        `CHK("oe", 1'b0, o_oe);
        `CHK("word", DATA_RST, {o_par, o_dq});
        @(negedge i_clk);
        i_nrst = 1'b1;
        // reset leaves the port deselected, so the next read is masked once
        ctl_u.cyc(IDL ^ K_CSTB, 18'h00012, 36'h0, 1'b0);
        rd_chk(1'b0, 2);
        ctl_u.cyc(IDL, 18'h00000, 36'h0, 1'b0);
        rd_chk(1'b1, 2);
    endtask : t_reset
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // about forty cycles of traffic, so four hundred means a hang
    initial
    begin
        #16000;
        errors++;
        close_out();
    end
    initial
    begin
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        i_nrst = 1'b1;
        // burst order strap needs two edges to settle
        repeat (3) ctl_u.cyc(IDL, 18'h00000, 36'h0, 1'b0);
        t_burst_write();
        t_lane_write();
        t_read_burst();
        t_strobe_ignored();
        t_interleave();
        t_reset();
        close_out();
    end
endmodule : tb_top
`default_nettype wire
